// [dsc_map.svh]
// dsc_map.svh: register offsets, field positions, reset values and counts
// assumes inclusion by the control block and its table memory
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH

`define DSC_OFS_CTRL0        8'h80
`define DSC_OFS_ROW1         8'h81
`define DSC_OFS_ROW2         8'h82
`define DSC_OFS_DIRECT1      8'h83
`define DSC_OFS_DIRECT2      8'h84
`define DSC_OFS_SRC_RANGE    8'h85
`define DSC_OFS_WREN         8'h86
`define DSC_OFS_RESULT       8'h87
`define DSC_TABLE1_BASE      8'h90
`define DSC_TABLE2_BASE      8'hd0
`define DSC_TABLE_END        8'hff

// control register 0 fields
`define DSC_C0_REF_SEL       0
`define DSC_C0_IN_SEL        1
`define DSC_C0_FILT_OFF      2
`define DSC_C0_DIR1          3
`define DSC_C0_DIR2          4
`define DSC_C0_VOL_SEL       5

// source and range register fields
`define DSC_SR_RANGE1_LSB    0
`define DSC_SR_RANGE2_LSB    2
`define DSC_SR_TAB1_DIRECT   4
`define DSC_SR_DAC1_DIRECT   5
`define DSC_SR_TAB2_DIRECT   6
`define DSC_SR_DAC2_DIRECT   7

`define DSC_WEL_BIT          7
`define DSC_WEL_SET_VALUE    8'h80
`define DSC_WEL_CLR_VALUE    8'h00
`define DSC_RESET_BYTE       8'h00
// earlier agreeing conversions needed, so the fourth in a row qualifies
`define DSC_FILTER_COUNT     2'd2

`endif

// [dsc_pkg.sv]
// dsc_pkg.sv: types shared by the sensor conditioner control logic
// assumes nothing beyond a systemverilog compiler
package dsc_pkg;
	typedef enum logic [2:0] {
		DSC_ST_WAIT_ADC = 3'b001,
		DSC_ST_QUALIFY  = 3'b010,
		DSC_ST_RUN      = 3'b100
	} dsc_state_t;

	typedef enum logic [1:0] {
		DSC_RANGE_EXTERNAL = 2'h0,
		DSC_RANGE_LOW      = 2'h1,
		DSC_RANGE_MID      = 2'h2,
		DSC_RANGE_HIGH     = 2'h3
	} dsc_range_t;
endpackage

// [dsc_tab_if.sv]
// dsc_tab_if.sv: port bundle between control logic and the table memory
// assumes one clock shared by both ends
interface dsc_tab_if;
	logic       wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic [5:0] rd_row1;
	logic [5:0] rd_row2;
	logic [7:0] rd_data1;
	logic [7:0] rd_data2;

	modport ctrl (output wr_en, wr_addr, wr_data, rd_row1, rd_row2, input rd_data1, rd_data2);
	modport mem  (input wr_en, wr_addr, wr_data, rd_row1, rd_row2, output rd_data1, rd_data2);
endinterface

// [dsc_tables.sv]
// dsc_tables.sv: the two 64-row look-up tables, registered read data
// assumes byte addresses from the serial slave, tables at fixed bases
`include "dsc_map.svh"

module dsc_tables (
	// clock
	input  wire logic i_core_clk,
	// table port
	dsc_tab_if.mem    tab
);
	logic [7:0] table_one [0:63];
	logic [7:0] table_two [0:63];
	wire        in_two = tab.wr_addr >= `DSC_TABLE2_BASE;
	wire  [7:0] wr_off = tab.wr_addr - (in_two ? `DSC_TABLE2_BASE : `DSC_TABLE1_BASE);

	// no reset on the array: contents are programmed, not defaulted
	always_ff @(posedge i_core_clk) begin
		if (tab.wr_en && !in_two)
			table_one[wr_off[5:0]] <= tab.wr_data;
		if (tab.wr_en && in_two)
			table_two[wr_off[5:0]] <= tab.wr_data;
		tab.rd_data1 <= table_one[tab.rd_row1];
		tab.rd_data2 <= table_two[tab.rd_row2];
	end
endmodule // dsc_tables

// [dsc_ctrl.sv]
// dsc_ctrl.sv: converter source select, range, write latch and adc result
// assumes a serial slave front end delivering byte writes and reads,
// and an adc delivering one result pulse per conversion
//
// Contract
// - direct byte two at 84h, volatility flag
// - dac2 direct bit seven picks direct byte
// - output one range code drives range
// - output two range code same decode
// - table one row: adc or field
// - table two row: adc or field
// - dac1 input: table row or register 3
// - dac2 input: table row or register 4
// - writes refused and nacked while latch clear
// - latch resets clear, 80h sets, 00h clears
// - latch write leaves other bits alone
// - result read-only; top six bits address tables
// - result is eight bit binary
// - filter needs four matching conversions
// - reference select bit, internal default
// - input select bit, sensor default
// - row address is base plus row
// - converters hold 00h until first qualified result; a dac in direct mode drives its direct byte at once
`include "dsc_map.svh"

module dsc_ctrl (
	// clock and reset
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	// register access from the serial slave
	input  wire logic       i_wr_stb,
	input  wire logic       i_rd_stb,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata,
	output logic            o_wr_ack,
	output logic            o_wr_nack,
	// adc conversions
	input  wire logic       i_adc_done,
	input  wire logic [7:0] i_adc_code,
	// analog controls
	output logic      [7:0] o_dac1_code,
	output logic      [7:0] o_dac2_code,
	output logic      [1:0] o_output1_range_code,
	output logic      [1:0] o_output2_range_code,
	output logic            o_output1_direction_select,
	output logic            o_output2_direction_select,
	output logic            o_reference_select,
	output logic            o_reference_drive,
	output logic            o_converter_input_select,
	output logic            o_direct_regs_volatility_select
);
	dsc_tab_if tab ();

	dsc_tables u_tables (
		.i_core_clk (i_core_clk),
		.tab        (tab)
	);

	logic [7:0]          control0;
	logic [5:0]          table1_row_field;
	logic [5:0]          table2_row_field;
	logic [7:0]          dac1_direct_value;
	logic [7:0]          dac2_direct_value;
	logic [7:0]          output_source_and_range;
	logic                write_enable_latch;
	logic [7:0]          converter_result;
	logic [7:0]          last_code;
	logic [1:0]          match_count;
	logic                rows_ready;
	dsc_pkg::dsc_state_t state;
	dsc_pkg::dsc_state_t next_state;

	function automatic logic [5:0] row_of(input logic sel, input logic [5:0] field,
		input logic [7:0] result);
		row_of = sel ? field : result[7:2];
	endfunction

	function automatic logic [7:0] dac_of(input logic sel, input logic [7:0] direct,
		input logic [7:0] row_byte);
		dac_of = sel ? direct : row_byte;
	endfunction

	// decode
	wire wr_hit       = i_wr_stb && write_enable_latch;
	wire wel_access   = i_wr_stb && i_addr == `DSC_OFS_WREN;
	wire wel_legal    = i_wdata == `DSC_WEL_SET_VALUE || i_wdata == `DSC_WEL_CLR_VALUE;
	wire table_write  = wr_hit && i_addr >= `DSC_TABLE1_BASE;
	wire regs_write   = wr_hit && i_addr >= `DSC_OFS_CTRL0 && i_addr <= `DSC_OFS_SRC_RANGE;
	wire write_taken  = regs_write || table_write || (wel_access && wel_legal);
	wire tab1_direct  = output_source_and_range[`DSC_SR_TAB1_DIRECT];
	wire tab2_direct  = output_source_and_range[`DSC_SR_TAB2_DIRECT];
	wire dac1_direct  = output_source_and_range[`DSC_SR_DAC1_DIRECT];
	wire dac2_direct  = output_source_and_range[`DSC_SR_DAC2_DIRECT];
	wire filter_off   = control0[`DSC_C0_FILT_OFF];
	wire top_match    = i_adc_code[7:2] == last_code[7:2] &&
		state != dsc_pkg::DSC_ST_WAIT_ADC; // no predecessor to agree with after reset
	wire qualified    = i_adc_done && (filter_off || (top_match &&
		match_count == `DSC_FILTER_COUNT));
	wire table_valid  = rows_ready;
	wire [7:0] next_dac1 = dac_of(dac1_direct, dac1_direct_value, tab.rd_data1);
	wire [7:0] next_dac2 = dac_of(dac2_direct, dac2_direct_value, tab.rd_data2);

	// table port
	assign tab.wr_en   = table_write;
	assign tab.wr_addr = i_addr;
	assign tab.wr_data = i_wdata;
	assign tab.rd_row1 = row_of(tab1_direct, table1_row_field, converter_result);
	assign tab.rd_row2 = row_of(tab2_direct, table2_row_field, converter_result);

	// read mux, reserved bits read as zero
	logic [7:0] next_rdata;
	always_comb begin
		next_rdata = `DSC_RESET_BYTE;
		unique case (i_addr)
			`DSC_OFS_CTRL0:     next_rdata = control0;
			`DSC_OFS_ROW1:      next_rdata = {2'h0, table1_row_field};
			`DSC_OFS_ROW2:      next_rdata = {2'h0, table2_row_field};
			`DSC_OFS_DIRECT1:   next_rdata = dac1_direct_value;
			`DSC_OFS_DIRECT2:   next_rdata = dac2_direct_value;
			`DSC_OFS_SRC_RANGE: next_rdata = output_source_and_range;
			`DSC_OFS_WREN:      next_rdata = {write_enable_latch, 7'h00};
			`DSC_OFS_RESULT:    next_rdata = converter_result;
			default:            next_rdata = `DSC_RESET_BYTE;
		endcase
	end

	// first qualified result releases the converters
	always_comb begin
		next_state = state;
		unique case (state)
			dsc_pkg::DSC_ST_WAIT_ADC: if (i_adc_done) next_state = dsc_pkg::DSC_ST_QUALIFY;
			dsc_pkg::DSC_ST_QUALIFY:  if (qualified) next_state = dsc_pkg::DSC_ST_RUN;
			dsc_pkg::DSC_ST_RUN:      next_state = dsc_pkg::DSC_ST_RUN;
			default:                  next_state = dsc_pkg::DSC_ST_WAIT_ADC;
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			state <= dsc_pkg::DSC_ST_WAIT_ADC;
		else
			state <= (i_adc_done && filter_off) ? dsc_pkg::DSC_ST_RUN : next_state;
	end

	// rows lag the result by the table read register, so release one cycle late
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			rows_ready <= 1'b0;
		else
			rows_ready <= state == dsc_pkg::DSC_ST_RUN;
	end

	// the latch is only written by the two legal patterns; anything else is ignored
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			write_enable_latch <= 1'b0;
		else if (wel_access && wel_legal)
			write_enable_latch <= i_wdata[`DSC_WEL_BIT];
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			control0                <= `DSC_RESET_BYTE;
			table1_row_field        <= 6'h00;
			table2_row_field        <= 6'h00;
			dac1_direct_value       <= `DSC_RESET_BYTE;
			dac2_direct_value       <= `DSC_RESET_BYTE;
			output_source_and_range <= `DSC_RESET_BYTE;
		end else if (regs_write) begin
			unique case (i_addr)
				`DSC_OFS_CTRL0:     control0 <= i_wdata;
				`DSC_OFS_ROW1:      table1_row_field <= i_wdata[5:0];
				`DSC_OFS_ROW2:      table2_row_field <= i_wdata[5:0];
				`DSC_OFS_DIRECT1:   dac1_direct_value <= i_wdata;
				`DSC_OFS_DIRECT2:   dac2_direct_value <= i_wdata;
				`DSC_OFS_SRC_RANGE: output_source_and_range <= i_wdata;
				default:            control0 <= control0;
			endcase
		end
	end

	// adc filter: counts agreeing conversions at the top six bits
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			last_code        <= `DSC_RESET_BYTE;
			match_count      <= 2'd0;
			converter_result <= `DSC_RESET_BYTE;
		end else if (i_adc_done) begin
			last_code   <= i_adc_code;
			match_count <= (top_match && match_count != `DSC_FILTER_COUNT) ?
				match_count + 2'd1 : (top_match ? match_count : 2'd0);
			if (qualified)
				converter_result <= i_adc_code;
		end
	end

	// outputs
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata                         <= `DSC_RESET_BYTE;
			o_wr_ack                        <= 1'b0;
			o_wr_nack                       <= 1'b0;
			o_dac1_code                     <= `DSC_RESET_BYTE;
			o_dac2_code                     <= `DSC_RESET_BYTE;
			o_output1_range_code            <= 2'h0;
			o_output2_range_code            <= 2'h0;
			o_output1_direction_select      <= 1'b0;
			o_output2_direction_select      <= 1'b0;
			o_reference_select              <= 1'b0;
			o_reference_drive               <= 1'b1;
			o_converter_input_select        <= 1'b0;
			o_direct_regs_volatility_select <= 1'b0;
		end else begin
			if (i_rd_stb)
				o_rdata <= next_rdata;
			o_wr_ack   <= i_wr_stb && write_taken;
			o_wr_nack  <= i_wr_stb && !write_taken;
			// table read data lag one cycle, so the row becomes valid a cycle after run
			o_dac1_code <= table_valid || dac1_direct ? next_dac1 : `DSC_RESET_BYTE;
			o_dac2_code <= table_valid || dac2_direct ? next_dac2 : `DSC_RESET_BYTE;
			o_output1_range_code <= output_source_and_range[`DSC_SR_RANGE1_LSB +: 2];
			o_output2_range_code <= output_source_and_range[`DSC_SR_RANGE2_LSB +: 2];
			o_output1_direction_select      <= control0[`DSC_C0_DIR1];
			o_output2_direction_select      <= control0[`DSC_C0_DIR2];
			o_reference_select              <= control0[`DSC_C0_REF_SEL];
			o_reference_drive               <= !control0[`DSC_C0_REF_SEL];
			o_converter_input_select        <= control0[`DSC_C0_IN_SEL];
			o_direct_regs_volatility_select <= control0[`DSC_C0_VOL_SEL];
		end
	end

	a_nack_no_latch: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr_stb && !write_enable_latch && i_addr != `DSC_OFS_WREN) |=> o_wr_nack)
		else $error("write without latch was not refused");

	a_latch_sets: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr_stb && i_addr == `DSC_OFS_WREN && i_wdata == `DSC_WEL_SET_VALUE)
		|=> write_enable_latch)
		else $error("latch did not set");

	a_latch_holds: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!(i_wr_stb && i_addr == `DSC_OFS_WREN) |=> $stable(write_enable_latch))
		else $error("latch changed without a write");

	a_dac_held_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state == dsc_pkg::DSC_ST_WAIT_ADC && !dac1_direct) |=> o_dac1_code == 8'h00)
		else $error("dac1 left zero before qualified result");

	a_dac2_direct: assert property (@(posedge i_core_clk) disable iff (i_rst)
		dac2_direct |=> o_dac2_code == $past(dac2_direct_value))
		else $error("dac2 did not follow its direct byte");

	a_dac1_direct: assert property (@(posedge i_core_clk) disable iff (i_rst)
		dac1_direct |=> o_dac1_code == $past(dac1_direct_value))
		else $error("dac1 did not follow its direct byte");

	a_row1_source: assert property (@(posedge i_core_clk) disable iff (i_rst)
		tab.rd_row1 == (tab1_direct ? table1_row_field : converter_result[7:2]))
		else $error("table one row source wrong");

	a_filter_hold: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_adc_done && !filter_off && !top_match) |=> $stable(converter_result))
		else $error("result updated on mismatching conversion");

	a_filter_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_adc_done && filter_off) |=> converter_result == $past(i_adc_code))
		else $error("unfiltered result not taken");

	a_range_follow: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_output1_range_code == $past(output_source_and_range[1:0]))
		else $error("range code not applied");

	a_row2_source: assert property (@(posedge i_core_clk) disable iff (i_rst)
		tab.rd_row2 == (tab2_direct ? table2_row_field : converter_result[7:2]))
		else $error("table two row source wrong");

	a_range2_follow: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_output2_range_code == $past(output_source_and_range[3:2]))
		else $error("range two code not applied");

	a_ref_drive: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_reference_drive != $past(control0[`DSC_C0_REF_SEL]))
		else $error("reference drive not opposite to select");

	a_input_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_converter_input_select == $past(control0[`DSC_C0_IN_SEL]))
		else $error("input select not applied");

	a_volatility_flag: assert property (@(posedge i_core_clk) disable iff (i_rst)
		##1 o_direct_regs_volatility_select == $past(control0[`DSC_C0_VOL_SEL]))
		else $error("volatility flag not applied");

	a_result_readonly: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr_stb && i_addr == `DSC_OFS_RESULT) |=> o_wr_nack)
		else $error("write to result register not refused");

	a_latch_clears: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr_stb && i_addr == `DSC_OFS_WREN && i_wdata == `DSC_WEL_CLR_VALUE)
		|=> !write_enable_latch)
		else $error("latch did not clear");

	a_locked_regs: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_wr_stb && !write_enable_latch) |=> ($stable(output_source_and_range) &&
		$stable(dac2_direct_value)))
		else $error("register changed while latch clear");

	a_dac2_held_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(state == dsc_pkg::DSC_ST_WAIT_ADC && !dac2_direct) |=> o_dac2_code == 8'h00)
		else $error("dac2 left zero before qualified result");

	a_filter_fourth: assert property (@(posedge i_core_clk) disable iff (i_rst)
		(i_adc_done && !filter_off && top_match && match_count == 2'd2)
		|=> converter_result == $past(i_adc_code))
		else $error("fourth agreeing conversion not taken");
endmodule // dsc_ctrl

// [dsc_host.sv]
// dsc_host.sv: register master model standing for host software
// assumes byte strobes into the control block, answers one cycle later
module dsc_host (
	// clock
	input  wire logic       i_core_clk,
	// register access
	output logic            o_wr_stb,
	output logic            o_rd_stb,
	output logic      [7:0] o_addr,
	output logic      [7:0] o_wdata,
	input  wire logic       i_wr_ack,
	input  wire logic       i_wr_nack
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		o_addr = 8'h00;
		o_wdata = 8'h00;
	end
	// caller sets the latch before other writes
	task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d,
		output logic ack, output logic nack);
		@(posedge i_core_clk);
		#1;
		o_addr = a;
		o_wdata = d;
		o_wr_stb = !rd;
		o_rd_stb = rd;
		@(posedge i_core_clk);
		#1;
		o_wr_stb = 1'b0;
		o_rd_stb = 1'b0;
		ack = i_wr_ack;
		nack = i_wr_nack;
		// released lines show no stale value
		o_addr = ~a;
		o_wdata = ~d;
	endtask
endmodule // dsc_host

// [tb_dac_source_select_and_adc_control.sv]
// tb_dac_source_select_and_adc_control.sv: self-checking bench of dsc_ctrl
// assumes the host model as register master; the bench drives the adc
module tb_dac_source_select_and_adc_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic       i_core_clk = 1'b0;
	logic       i_rst = 1'b1;
	logic       wr_stb, rd_stb, wr_ack, wr_nack, adc_done = 1'b0;
	logic [7:0] addr, wdata, rdata, adc_code = 8'h00, dac1, dac2;
	logic [1:0] rng1, rng2;
	logic       dir1, dir2, ref_sel, ref_drv, in_sel, vol_sel;
	int         n_fail = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	always #25 i_core_clk = ~i_core_clk;
	dsc_host dsc_host_inst (.i_core_clk(i_core_clk), .o_wr_stb(wr_stb), .o_rd_stb(rd_stb),
		.o_addr(addr), .o_wdata(wdata), .i_wr_ack(wr_ack), .i_wr_nack(wr_nack));
	dsc_ctrl dsc_ctrl_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_wr_stb(wr_stb),
		.i_rd_stb(rd_stb), .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
		.o_wr_ack(wr_ack), .o_wr_nack(wr_nack), .i_adc_done(adc_done), .i_adc_code(adc_code),
		.o_dac1_code(dac1), .o_dac2_code(dac2), .o_output1_range_code(rng1),
		.o_output2_range_code(rng2), .o_output1_direction_select(dir1),
		.o_output2_direction_select(dir2), .o_reference_select(ref_sel),
		.o_reference_drive(ref_drv), .o_converter_input_select(in_sel),
		.o_direct_regs_volatility_select(vol_sel));
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ok);
		logic ack, nack;
		dsc_host_inst.access(1'b0, a, d, ack, nack);
		chk1(ack, ok, "write ack");
		chk1(nack, !ok, "write nack");
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic ack, nack;
		dsc_host_inst.access(1'b1, a, 8'h00, ack, nack);
		chk8(rdata, exp, "read data");
	endtask
	task automatic adc(input logic [7:0] code);
		@(posedge i_core_clk);
		#1;
		adc_done = 1'b1;
		adc_code = code;
		@(posedge i_core_clk);
		#1;
		adc_done = 1'b0;
		adc_code = ~code;
		repeat (3) @(posedge i_core_clk);
	endtask
	task automatic t_reset();
		chk1(ref_drv, 1'b1, "ref drive");
		chk1(in_sel, 1'b0, "input select");
		chk8({4'h0, rng2, rng1}, 8'h00, "ranges");
		rd(8'h86, 8'h00);
		rd(8'h85, 8'h00);
	endtask
	task automatic t_locked();
		wr(8'h84, 8'h5a, 1'b0);
		wr(8'h86, 8'h40, 1'b0);
		rd(8'h84, 8'h00);
	endtask
	task automatic t_regs();
		wr(8'h86, 8'h80, 1'b1);
		rd(8'h86, 8'h80);
		wr(8'h84, 8'ha5, 1'b1);
		wr(8'h87, 8'h33, 1'b0);
		rd(8'h84, 8'ha5);
		rd(8'h87, 8'h00);
		wr(8'h80, 8'h03, 1'b1);
		repeat (2) @(posedge i_core_clk);
		chk1(ref_sel, 1'b1, "ref select");
		chk1(ref_drv, 1'b0, "ref drive");
		chk1(in_sel, 1'b1, "input select");
	endtask
	task automatic t_range();
		for (int i = 0; i < 4; i++) begin
			wr(8'h85, {4'h0, 2'(3 - i), 2'(i)}, 1'b1);
			repeat (2) @(posedge i_core_clk);
			chk8({6'h00, rng1}, 8'(i), "range one");
			chk8({6'h00, rng2}, 8'(3 - i), "range two");
		end
	endtask
	task automatic t_direct();
		wr(8'h83, 8'h3c, 1'b1);
		wr(8'h85, 8'ha0, 1'b1);
		repeat (4) @(posedge i_core_clk);
		chk8(dac1, 8'h3c, "dac one direct");
		chk8(dac2, 8'ha5, "dac two direct");
		wr(8'h84, 8'h69, 1'b1);
		repeat (4) @(posedge i_core_clk);
		chk8(dac2, 8'h69, "dac two follows");
	endtask
	task automatic t_adc();
		wr(8'h80, 8'h04, 1'b1);
		adc(8'hc7);
		rd(8'h87, 8'hc7);
		adc(8'hff);
		rd(8'h87, 8'hff);
		wr(8'h80, 8'h00, 1'b1);
		adc(8'h10);
		adc(8'h11);
		adc(8'h12);
		rd(8'h87, 8'hff);
		adc(8'h13);
		rd(8'h87, 8'h13);
	endtask
	task automatic t_unlock();
		wr(8'h86, 8'h00, 1'b1);
		wr(8'h84, 8'h11, 1'b0);
		rd(8'h84, 8'h69);
	endtask
	task automatic t_table();
		wr(8'h94, 8'h5e, 1'b1);
		wr(8'hd4, 8'he1, 1'b1);
		wr(8'h85, 8'h00, 1'b1);
		repeat (3) @(posedge i_core_clk);
		chk8(dac1, 8'h5e, "dac one adc row");
		chk8(dac2, 8'he1, "dac two adc row");
		wr(8'h81, 8'h0a, 1'b1);
		wr(8'h82, 8'h0b, 1'b1);
		wr(8'h9a, 8'h77, 1'b1);
		wr(8'hdb, 8'h88, 1'b1);
		wr(8'h85, 8'h50, 1'b1);
		repeat (3) @(posedge i_core_clk);
		chk8(dac1, 8'h77, "dac one field row");
		chk8(dac2, 8'h88, "dac two field row");
		rd(8'h81, 8'h0a);
	endtask
	task automatic t_again();
		wr(8'h86, 8'h80, 1'b1);
		@(posedge i_core_clk);
		#1;
		i_rst = 1'b1;
		repeat (4) @(posedge i_core_clk);
		#1;
		i_rst = 1'b0;
		chk8(dac1, 8'h00, "dac one after reset");
		chk8(dac2, 8'h00, "dac two after reset");
		rd(8'h86, 8'h00);
		adc(8'h10);
		adc(8'h11);
		adc(8'h12);
		chk8(dac1, 8'h00, "dac one before qualified");
		rd(8'h87, 8'h00);
		adc(8'h13);
		repeat (2) @(posedge i_core_clk);
		chk8(dac1, 8'h5e, "dac one first row");
		chk8(dac2, 8'he1, "dac two first row");
		rd(8'h87, 8'h13);
	endtask
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		// whole run needs well under a thousand cycles
		if (cyc == 3000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (4) @(posedge i_core_clk);
		#1;
		i_rst = 1'b0;
		t_reset();
		t_locked();
		t_regs();
		t_range();
		t_direct();
		t_adc();
		t_table();
		t_unlock();
		t_again();
		end_sim();
	end
endmodule // tb_dac_source_select_and_adc_control
